/* rtl/ugc_pkg.sv */
// Package for the USB device global control block: register map, fields, resets.
// Assumes a 32-bit APB slave with word-aligned registers.
package ugc_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_DEV_ADDRESS = 8'h08;
  localparam logic [7:0] ADDR_DMA_CURRENT = 8'h0C;
  localparam logic [7:0] ADDR_INT_FLAGS = 8'h10;
  // Interrupt enable fields
  localparam int IE_SOF = 7;
  localparam int IE_NAK = 6;
  localparam int IE_FIFO_OV = 4;
  localparam int IE_SUSPEND = 2;
  localparam int IE_TRANSFER = 1;
  localparam int IE_BUS_RST = 0;
  localparam logic [7:0] IE_WRITE_MASK = 8'hD7;
  localparam logic [7:0] IE_RESET = 8'h00;
  // Control fields
  localparam int CT_LOW_SPEED = 6;
  localparam int CT_SYS_HIGH = 5;
  localparam int CT_SYS_LOW = 4;
  localparam int CT_INT_BUSY = 3;
  localparam int CT_RESET_PE = 2;
  localparam int CT_CLR_ALL = 1;
  localparam int CT_DMA_EN = 0;
  localparam logic [7:0] CT_WRITE_MASK = 8'h7F;
  localparam logic [7:0] CT_RESET = 8'h06;
  // Address register fields
  localparam int DA_GP_BIT = 7;
  localparam logic [7:0] DA_RESET = 8'h00;
  // Flag bits: sof, nak, fifo overflow, suspend/wake, transfer, bus reset
  localparam int FLAG_COUNT = 6;
  localparam logic [FLAG_COUNT-1:0] FLAG_RESET = 6'h00;
  // Upper nibble of the DMA high byte is fixed zero
  localparam int DMA_HIGH_BITS = 4;
  localparam logic [1:0] SYS_OFF = 2'h0;
  localparam logic [1:0] SYS_EXT_PULLUP = 2'h1;
  localparam logic [1:0] SYS_INT_PULLUP = 2'h2;

  typedef struct packed {
    logic [5:0] flag;
  } ugc_events_s;

  typedef struct packed {
    logic device_enable;
    logic internal_pullup;
    logic slow_rate_select;
    logic engine_reset;
    logic clear_flags_and_fifo;
    logic dma_enable;
    logic nak_busy;
    logic [6:0] device_address;
  } ugc_ctrl_s;
endpackage : ugc_pkg

/* rtl/ugc_flags.sv */
// Sticky event flag bank with write-one-to-clear and a forced clear.
// Assumes events are synchronous single-cycle pulses on the same clock.
`timescale 1ns/100ps
`default_nettype none
module ugc_flags #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Events and clears
  input wire logic [WIDTH-1:0] event_set,
  input wire logic [WIDTH-1:0] clear_ones,
  input wire logic clear_all,
  // Flags
  output logic [WIDTH-1:0] flag
);
  typedef struct packed {
    logic [WIDTH-1:0] flag;
  } ugc_flag_state_s;

  ugc_flag_state_s state;
  ugc_flag_state_s next_state;

  initial begin
    if (WIDTH < 1) $error("ugc_flags: WIDTH must be positive");
  end

  always_comb begin
    next_state = state;
    // Forced clear wins, otherwise a new event beats a clear in the same cycle
    if (clear_all) begin
      next_state.flag = '0;
    end else begin
      next_state.flag = (state.flag & ~clear_ones) | event_set;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flag = state.flag;
endmodule // ugc_flags
`default_nettype wire

/* rtl/ugc_global_control.sv */
// Global control of a USB full/low-speed device: enables, control, address, DMA address.
// Assumes an APB master on the system clock and a protocol engine fed from ugc_ctrl_s.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Bit 7 enables start-of-frame interrupt
// - Bit 6 enables NAK-received interrupt
// - Bit 4 enables FIFO overflow interrupt
// - Bit 2 enables suspend or wake interrupt
// - Bit 1 enables transfer-complete interrupt
// - Bit 0 enables bus reset interrupt
// - Speed bit: zero full, one low
// - Control bit 5 enables device and pull-up
// - Bits 5:4 select pull-up and enable mode
// - Bit 3 NAKs while transfer flag pending
// - Bit 2 holds engine reset, resets one
// - Bit 1 clears flags and FIFO, resets one
// - Bit 0 enables DMA only
// - Respond only to seven-bit device address
// - Address bit 7 is free software flag
// - DMA high byte: four bits, rest zero
// - DMA low byte reports current address
// - Engine events set flags, request interrupt
// - Flags stay until software clears them
module ugc_global_control #(
  parameter int DMA_WIDTH = 12
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Protocol engine events, one-cycle pulses
  input wire logic ev_sof,
  input wire logic ev_nak,
  input wire logic ev_fifo_overflow,
  input wire logic ev_suspend_wake,
  input wire logic ev_transfer_done,
  input wire logic ev_bus_reset,
  // Incoming token address from the engine
  input wire logic token_valid,
  input wire logic [6:0] token_address,
  // DMA engine current address
  input wire logic [DMA_WIDTH-1:0] dma_current,
  // Control to engine and transceiver
  output ugc_pkg::ugc_ctrl_s ctrl,
  output logic address_match,
  output logic force_nak,
  output logic usb_irq
);
  typedef struct packed {
    logic [7:0] int_enable;
    logic [7:0] control;
    logic [7:0] dev_address;
    logic [31:0] rdata;
    logic address_match;
  } ugc_state_s;

  ugc_state_s state;
  ugc_state_s next_state;
  // Kept apart from the state struct: it is the only register on the raw reset
  logic [1:0] rst_sync;
  logic rst_int_b;
  logic [5:0] flag;
  logic [5:0] clear_ones;
  logic [5:0] event_set;
  logic wr_access;
  logic rd_access;
  logic addr_ok;

  initial begin
    if (DMA_WIDTH < 9 || DMA_WIDTH > 8 + ugc_pkg::DMA_HIGH_BITS)
      $error("ugc_global_control: DMA_WIDTH out of range");
  end

  // Map enable bits to the flag order: sof, nak, ovf, susp, xfer, brst
  function automatic logic [5:0] enable_vector(input logic [7:0] ie);
    enable_vector = {ie[ugc_pkg::IE_SOF], ie[ugc_pkg::IE_NAK], ie[ugc_pkg::IE_FIFO_OV],
                     ie[ugc_pkg::IE_SUSPEND], ie[ugc_pkg::IE_TRANSFER],
                     ie[ugc_pkg::IE_BUS_RST]};
  endfunction

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == ugc_pkg::ADDR_INT_ENABLE) || (a == ugc_pkg::ADDR_CONTROL) ||
                 (a == ugc_pkg::ADDR_DEV_ADDRESS) || (a == ugc_pkg::ADDR_DMA_CURRENT) ||
                 (a == ugc_pkg::ADDR_INT_FLAGS);
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_int_b = rst_sync[1];

  assign addr_ok = known_addr(paddr);
  assign wr_access = psel && penable && pwrite && addr_ok;
  assign rd_access = psel && !penable && !pwrite;
  assign event_set = {ev_sof, ev_nak, ev_fifo_overflow, ev_suspend_wake, ev_transfer_done,
                      ev_bus_reset};
  assign clear_ones = (wr_access && paddr == ugc_pkg::ADDR_INT_FLAGS) ? pwdata[5:0] : 6'h00;

  ugc_flags #(
    .WIDTH(ugc_pkg::FLAG_COUNT)
  ) u_flags (
    .clock(clock),
    .rst_b(rst_int_b),
    .event_set(event_set),
    .clear_ones(clear_ones),
    .clear_all(state.control[ugc_pkg::CT_CLR_ALL]),
    .flag(flag)
  );

  always_comb begin
    next_state = state;
    if (wr_access) begin
      if (paddr == ugc_pkg::ADDR_INT_ENABLE) begin
        next_state.int_enable = pwdata[7:0] & ugc_pkg::IE_WRITE_MASK;
      end else if (paddr == ugc_pkg::ADDR_CONTROL) begin
        next_state.control = pwdata[7:0] & ugc_pkg::CT_WRITE_MASK;
      end else if (paddr == ugc_pkg::ADDR_DEV_ADDRESS) begin
        next_state.dev_address = pwdata[7:0];
      end
    end
    // Read data is captured in setup so it stands through the access phase
    if (rd_access) begin
      next_state.rdata = 32'h0000_0000;
      if (paddr == ugc_pkg::ADDR_INT_ENABLE) begin
        next_state.rdata[7:0] = state.int_enable;
      end else if (paddr == ugc_pkg::ADDR_CONTROL) begin
        next_state.rdata[7:0] = state.control;
      end else if (paddr == ugc_pkg::ADDR_DEV_ADDRESS) begin
        next_state.rdata[7:0] = state.dev_address;
      end else if (paddr == ugc_pkg::ADDR_DMA_CURRENT) begin
        next_state.rdata[DMA_WIDTH-1:0] = dma_current;
      end else if (paddr == ugc_pkg::ADDR_INT_FLAGS) begin
        next_state.rdata[5:0] = flag;
      end
    end
    next_state.address_match = token_valid &&
      (token_address == state.dev_address[6:0]);
  end

  always_ff @(posedge clock or negedge rst_int_b) begin
    if (!rst_int_b) begin
      state.int_enable <= ugc_pkg::IE_RESET;
      state.control <= ugc_pkg::CT_RESET;
      state.dev_address <= ugc_pkg::DA_RESET;
      state.rdata <= 32'h0000_0000;
      state.address_match <= 1'b0;
    end else begin
      state.int_enable <= next_state.int_enable;
      state.control <= next_state.control;
      state.dev_address <= next_state.dev_address;
      state.rdata <= next_state.rdata;
      state.address_match <= next_state.address_match;
    end
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = state.rdata;

  // Control decode toward the engine and transceiver
  always_comb begin
    ctrl.slow_rate_select = state.control[ugc_pkg::CT_LOW_SPEED];
    // Code 11 is undefined; treated as the internal pull-up mode through bit 5
    ctrl.device_enable = state.control[ugc_pkg::CT_SYS_HIGH] ||
                         state.control[ugc_pkg::CT_SYS_LOW];
    ctrl.internal_pullup = state.control[ugc_pkg::CT_SYS_HIGH];
    ctrl.engine_reset = state.control[ugc_pkg::CT_RESET_PE];
    ctrl.clear_flags_and_fifo = state.control[ugc_pkg::CT_CLR_ALL];
    ctrl.dma_enable = state.control[ugc_pkg::CT_DMA_EN];
    ctrl.nak_busy = state.control[ugc_pkg::CT_INT_BUSY];
    ctrl.device_address = state.dev_address[6:0];
  end

  assign address_match = state.address_match;
  // Pause with NAK while a completed transfer is still flagged
  assign force_nak = state.control[ugc_pkg::CT_INT_BUSY] && flag[1];
  // Any enabled flag raises the interrupt, engine held in reset or not
  assign usb_irq = |(flag & enable_vector(state.int_enable));
endmodule // ugc_global_control
`default_nettype wire

/* verification/ugc_properties.sv */
// Checker for the USB device global control block.
// Assumes one clock domain; bound to the design's top module below.
`timescale 1ns/100ps
`default_nettype none
module ugc_properties #(
  parameter int DMA_WIDTH = 12
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Engine side
  input wire logic ev_transfer_done,
  input wire logic token_valid,
  input wire logic [6:0] token_address,
  input wire logic [DMA_WIDTH-1:0] dma_current,
  input wire logic address_match,
  input wire logic force_nak,
  input wire logic usb_irq,
  input wire ugc_pkg::ugc_ctrl_s ctrl
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  sequence s_ctrl_write;
    psel && penable && pwrite && paddr == ugc_pkg::ADDR_CONTROL;
  endsequence
  sequence s_dma_setup;
    psel && !penable && !pwrite && paddr == ugc_pkg::ADDR_DMA_CURRENT;
  endsequence
  a_unmapped_error: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
    else $error("unmapped access without error");
  a_dma_capture: assert property (s_dma_setup |=> prdata == 32'($past(dma_current)))
    else $error("dma address read wrong");
  a_speed_select: assert property (s_ctrl_write |=> ctrl.slow_rate_select == $past(pwdata[6]))
    else $error("speed select wrong");
  a_system_decode: assert property (s_ctrl_write |=> ctrl.internal_pullup == $past(pwdata[5])
    && ctrl.device_enable == ($past(pwdata[5]) || $past(pwdata[4])))
    else $error("system control decode wrong");
  a_reset_dma_bits: assert property (s_ctrl_write |=> ctrl.engine_reset == $past(pwdata[2])
    && ctrl.dma_enable == $past(pwdata[0]))
    else $error("engine reset or dma enable wrong");
  a_token_match: assert property (token_valid && token_address == ctrl.device_address
    |=> address_match)
    else $error("own address not matched");
  a_token_idle: assert property (!token_valid |=> !address_match)
    else $error("match without token");
  a_clear_quiet: assert property (ctrl.clear_flags_and_fifo && $past(ctrl.clear_flags_and_fifo)
    |-> !usb_irq && !force_nak)
    else $error("flags live while cleared");
  a_nak_pause: assert property (ev_transfer_done && ctrl.nak_busy
    && !ctrl.clear_flags_and_fifo && !psel |=> force_nak)
    else $error("no nak pause after transfer");
  a_flag_sticky: assert property (force_nak && !psel |=> force_nak)
    else $error("transfer flag dropped alone");
endmodule // ugc_properties
bind ugc_global_control ugc_properties #(.DMA_WIDTH(DMA_WIDTH)) u_props (.*);
`default_nettype wire

/* verification/ugc_engine_model.sv */
// Protocol engine stand-in: event pulses, token addresses, DMA pointer.
// Assumes bench requests are one cycle long and on the same clock.
`timescale 1ns/100ps
`default_nettype none
module ugc_engine_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Bench requests
  input wire logic [5:0] fire,
  input wire logic tok_req,
  input wire logic [6:0] tok_addr,
  input wire logic [11:0] dma_set,
  // Engine outputs
  output ugc_pkg::ugc_events_s ev,
  output logic token_valid,
  output logic [6:0] token_address,
  output logic [11:0] dma_current
);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ev <= '0;
      token_valid <= 1'b0;
      token_address <= 7'h00;
      dma_current <= 12'h000;
    end else begin
      ev.flag <= fire;
      token_valid <= tok_req;
      // Idle token bus toggles so a stale address never matches by luck
      token_address <= tok_req ? tok_addr : ~token_address;
      dma_current <= dma_set;
    end
  end
endmodule // ugc_engine_model
`default_nettype wire

/* verification/usb_device_global_control_tb_top.sv */
// Self-checking bench for the USB device global control block.
// Assumes the engine model and the bound checker beside the design.
`timescale 1ns/100ps
`default_nettype none
module usb_device_global_control_tb_top;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tok_req = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, rnd = 32'h88DB;
  logic pready, pslverr, perr, token_valid, address_match, force_nak, usb_irq;
  logic ev_sof, ev_nak, ev_fifo_overflow, ev_suspend_wake, ev_transfer_done, ev_bus_reset;
  logic [5:0] fire = 6'h00;
  logic [6:0] token_address, tok_addr = 7'h00;
  logic [11:0] dma_current, dma_set = 12'h000;
  ugc_pkg::ugc_events_s ev;
  ugc_pkg::ugc_ctrl_s ctrl;
  int err_total = 0, n_compared = 0, cycles = 0;
  int iebit [6] = '{0, 1, 2, 4, 6, 7};
  assign {ev_sof, ev_nak, ev_fifo_overflow, ev_suspend_wake, ev_transfer_done, ev_bus_reset} = ev.flag;
  ugc_global_control #(.DMA_WIDTH(12)) u_dut (.*);
  ugc_engine_model u_eng (.*);
  always #5 clock = ~clock;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] sys_decode(input logic [1:0] c);
    return {30'h0, c != 2'h0, c[1]};
  endfunction
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // A write lands at the edge just passed; compare outputs once settled
    @(negedge clock);
  endtask
  task automatic pulse(input logic [5:0] f);
    @(posedge clock);
    fire <= f;
    @(posedge clock);
    fire <= 6'h00;
    repeat (2) @(posedge clock);
  endtask
  task automatic token(input logic [6:0] a, input logic hit);
    @(posedge clock);
    tok_req <= 1'b1;
    tok_addr <= a;
    @(posedge clock);
    tok_req <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    check("address match", {31'h0, hit}, {31'h0, address_match});
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    apb(1'b0, ugc_pkg::ADDR_CONTROL, 32'h0);
    check("control reset", 32'h06, q);
    apb(1'b1, ugc_pkg::ADDR_INT_ENABLE, 32'hFFFFFFFF);
    apb(1'b0, ugc_pkg::ADDR_INT_ENABLE, 32'h0);
    check("enable mask", 32'hD7, q);
    apb(1'b1, ugc_pkg::ADDR_CONTROL, 32'hFF);
    apb(1'b0, ugc_pkg::ADDR_CONTROL, 32'h0);
    check("control mask", 32'h7F, q);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, ugc_pkg::ADDR_CONTROL, 32'(i) << 4);
      check("speed", {31'h0, i[2]}, {31'h0, ctrl.slow_rate_select});
      check("sysctl", sys_decode(i[1:0]), {30'h0, ctrl.device_enable, ctrl.internal_pullup});
    end
    $display("test control_fields done");
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ugc_pkg::ADDR_INT_ENABLE, 32'hD7 & ~(32'h1 << iebit[i]));
      pulse(6'h01 << i);
      check("masked irq", 32'h0, {31'h0, usb_irq});
      apb(1'b1, ugc_pkg::ADDR_INT_ENABLE, 32'h1 << iebit[i]);
      check("enabled irq", 32'h1, {31'h0, usb_irq});
      apb(1'b0, ugc_pkg::ADDR_INT_FLAGS, 32'h0);
      check("flag", 32'h1 << i, q);
      apb(1'b1, ugc_pkg::ADDR_INT_FLAGS, 32'h1 << i);
      check("cleared irq", 32'h0, {31'h0, usb_irq});
    end
    $display("test irq_gating done");
    apb(1'b1, ugc_pkg::ADDR_CONTROL, 32'h08);
    pulse(6'h02);
    check("nak pause", 32'h1, {31'h0, force_nak});
    apb(1'b1, ugc_pkg::ADDR_INT_FLAGS, 32'h02);
    check("nak release", 32'h0, {31'h0, force_nak});
    apb(1'b1, ugc_pkg::ADDR_INT_ENABLE, 32'hD7);
    apb(1'b1, ugc_pkg::ADDR_CONTROL, 32'h02);
    pulse(6'h3F);
    apb(1'b0, ugc_pkg::ADDR_INT_FLAGS, 32'h0);
    check("flags held", 32'h0, q);
    check("irq held", 32'h0, {31'h0, usb_irq});
    $display("test nak_and_clear done");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      apb(1'b1, ugc_pkg::ADDR_DEV_ADDRESS, {24'h0, rnd[7:0]});
      apb(1'b0, ugc_pkg::ADDR_DEV_ADDRESS, 32'h0);
      check("address", {24'h0, rnd[7:0]}, q);
      token(rnd[6:0], 1'b1);
      token(~rnd[6:0], 1'b0);
    end
    @(posedge clock);
    dma_set <= rnd[19:8];
    apb(1'b0, ugc_pkg::ADDR_DMA_CURRENT, 32'h0);
    check("dma address", {20'h0, rnd[19:8]}, q);
    apb(1'b1, 8'h14, 32'hFF);
    check("unmapped error", 32'h1, {31'h0, perr});
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped", 32'h0, q);
    $display("test address_dma done");
    wrap_up();
  end
endmodule // usb_device_global_control_tb_top
`default_nettype wire
